// ---- pkg/fcd_pkg.sv ----
// Constants and types for the flash command decoder
package fcd_pkg;
  // Command codes
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_READ_ID      = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY   = 8'h98;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_WORD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_BUF_PROGRAM  = 8'he8;
  localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
  localparam logic [7:0] CMD_FACTORY_SET  = 8'h80;
  localparam logic [7:0] CMD_SUSPEND      = 8'hb0;
  // Status register layout and reset value
  localparam logic [7:0] STATUS_RESET     = 8'h80;
  localparam int         STATUS_READY_BIT = 7;
  localparam int         STATUS_ERASE_BIT = 5;
  localparam int         STATUS_PROG_BIT  = 4;
  localparam int         STATUS_SUSP_BIT  = 2;
  // Buffer limit in words
  localparam int         BUF_MAX_WORDS    = 512;
  // Read modes
  typedef enum logic [1:0] {RD_ARRAY, RD_STATUS, RD_ID, RD_QUERY} fcd_read_t;
  // Decoder states
  typedef enum logic [2:0] {
    ST_IDLE, ST_WORD_ADDR, ST_BUF_COUNT, ST_BUF_DATA, ST_BUF_CONFIRM,
    ST_FACTORY_ARM, ST_BUSY, ST_FACTORY
  } fcd_state_t;
endpackage

// ---- src/fcd_command_decoder.sv ----
// Command decoder: interprets bus writes, read mode, status, program requests
// Notes on behaviour
// [RULE1] 0xFF selects array read on sixteen lines
// [RULE2] 0x70 selects status read, low byte
// [RULE3] Accepted program enters status read automatically
// [RULE4] 0x90 selects identifier read, sixteen lines
// [RULE5] 0x98 selects query read, low byte
// [RULE6] Error bits cleared only by 0x50
// [RULE7] After 0x40 next write programs location
// [RULE8] Busy program obeys only status, suspend
// [RULE9] Host toggles select between async polls
// [RULE10] Host toggles select during sync polls
// [RULE11] Host writes array read after programming
// [RULE12] 0xE8 loads buffer, at most 512 words
// [RULE13] Confirm 0xD0 transfers buffer to array
// [RULE14] 0x80 arms factory program, awaits 0xD0
// [RULE15] Running factory program ignores all commands
// [RULE16] 0xD0 starts factory only after 0x80
// [RULE17] Decoder has no address; every write decoded
// [RULE18] Program algorithm runs internally, host polls
// [RULE19] Host reissues setup after die switch
// [RULE20] Capture on first rising write or select
// [RULE21] Reset gives array read, status 0x80
// [RULE22] Bad second word sets bits four, five
// [RULE23] Read mode holds until changed
`timescale 1ns/1ps
module fcd_command_decoder
  import fcd_pkg::*;
#(
  parameter int AW       = 16,            // Address width
  parameter int BUF_WORDS = BUF_MAX_WORDS  // Program buffer depth
) (
  // Clock, reset and freeze
  input  wire logic          sys_clk,
  input  wire logic          nrst,
  input  wire logic          clk_en,
  // Parallel bus strobes, sampled synchronously
  input  wire logic          chip_sel_n,
  input  wire logic          write_en_n,
  input  wire logic [AW-1:0] bus_addr,
  input  wire logic [15:0]   bus_data,
  // Read side: selected mode and status
  output logic [1:0]         read_mode,
  output logic [7:0]         status_reg,
  // Program request toward the array engine
  output logic               prog_valid,
  input  wire logic          prog_ready,
  output logic [AW-1:0]      prog_addr,
  output logic [15:0]        prog_data,
  output logic               prog_factory,
  // Completion from the array engine
  input  wire logic          prog_done,
  input  wire logic          prog_fail
);
  localparam int CW = $clog2(BUF_WORDS + 1);

  // Strobe history for edge detection
  logic cs_q, we_q;
  logic write_edge;
  // Decoder state
  fcd_state_t state, next_state;
  fcd_read_t  rmode, next_rmode;
  logic [7:0] status, next_status;
  logic [CW-1:0] words_left, next_words_left;
  logic       busy_factory, next_busy_factory;
  // Word pushed into the two-entry buffer
  logic            push_valid;
  logic            push_ready;
  logic [AW-1:0]   push_addr;
  logic [15:0]     push_data;
  logic [7:0]      cmd;
  // Two-entry buffer storage
  logic [AW+15:0] slot [2];
  logic [AW+15:0] next_slot0, next_slot1;
  logic [1:0]     fill, next_fill;
  logic           push_fac, next_push_fac;

  assign cmd = bus_data[7:0];

  // [RULE20] first rising strobe
  // Write ends when either strobe rises while both were low
  assign write_edge = (!cs_q && !we_q) && (chip_sel_n || write_en_n);

  // Strobe history register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cs_q <= 1'b1;
      we_q <= 1'b1;
    end else if (clk_en) begin
      cs_q <= chip_sel_n;
      we_q <= write_en_n;
    end
  end

  // Decoder next state
  always_comb begin
    next_state        = state;
    next_rmode        = rmode;
    next_status       = status;
    next_words_left   = words_left;
    next_busy_factory = busy_factory;
    push_valid        = 1'b0;
    push_addr         = bus_addr;
    push_data         = bus_data;
    // Completion from the engine; no write below clears ready in ST_BUSY or ST_FACTORY
    if ((state == ST_BUSY || state == ST_FACTORY) && prog_done && fill == 2'd0) begin
      next_state = ST_IDLE;
      next_status[STATUS_READY_BIT] = 1'b1;
    end
    // [RULE17] every write decoded
    if (write_edge) begin
      case (state)
        ST_IDLE: begin
          if (cmd == CMD_READ_ARRAY) begin
            // [RULE1] array mode
            next_rmode = RD_ARRAY;
          end else if (cmd == CMD_READ_STATUS) begin
            // [RULE2] status mode
            next_rmode = RD_STATUS;
          end else if (cmd == CMD_READ_ID) begin
            // [RULE4] identifier mode
            next_rmode = RD_ID;
          end else if (cmd == CMD_READ_QUERY) begin
            // [RULE5] query mode
            next_rmode = RD_QUERY;
          end else if (cmd == CMD_CLEAR_STATUS) begin
            // [RULE6] clear error bits
            next_status[STATUS_ERASE_BIT] = 1'b0;
            next_status[STATUS_PROG_BIT]  = 1'b0;
            next_status[3] = 1'b0;
            next_status[1] = 1'b0;
          end else if (cmd == CMD_WORD_PROGRAM) begin
            next_state = ST_WORD_ADDR;
            next_rmode = RD_STATUS;
          end else if (cmd == CMD_BUF_PROGRAM) begin
            next_state = ST_BUF_COUNT;
            next_rmode = RD_STATUS;
          end else if (cmd == CMD_FACTORY_SET) begin
            // [RULE14] arm factory program
            next_state = ST_FACTORY_ARM;
            next_rmode = RD_STATUS;
          end
          // Other codes leave mode alone
        end
        ST_WORD_ADDR: begin
          // [RULE7] latch address and data
          push_valid = 1'b1;
          next_busy_factory = 1'b0;
          next_state = ST_BUSY;
          next_status[STATUS_READY_BIT] = 1'b0;
          // [RULE3] auto status read
          next_rmode = RD_STATUS;
        end
        ST_BUF_COUNT: begin
          // [RULE12] count of words, N-1 coded; a count past buffer depth sets error bits and returns to idle
          if (bus_data >= 16'(BUF_WORDS)) begin
            next_status[STATUS_ERASE_BIT] = 1'b1;
            next_status[STATUS_PROG_BIT]  = 1'b1;
            next_state = ST_IDLE;
          end else begin
            next_words_left = CW'(bus_data + 16'd1);
            next_state = ST_BUF_DATA;
            next_status[STATUS_READY_BIT] = 1'b0;
          end
        end
        ST_BUF_DATA: begin
          // [RULE12] stream into buffer
          push_valid = 1'b1;
          next_busy_factory = 1'b0;
          next_words_left = words_left - CW'(1);
          if (words_left == CW'(1)) begin
            next_state = ST_BUF_CONFIRM;
          end
        end
        ST_BUF_CONFIRM: begin
          // [RULE13] confirm transfers buffer
          if (cmd == CMD_CONFIRM) begin
            next_state = ST_BUSY;
          end else begin
            // [RULE22] sequence error
            next_status[STATUS_ERASE_BIT] = 1'b1;
            next_status[STATUS_PROG_BIT]  = 1'b1;
            next_status[STATUS_READY_BIT] = 1'b1;
            next_state = ST_IDLE;
          end
          // [RULE3] auto status read
          next_rmode = RD_STATUS;
        end
        ST_FACTORY_ARM: begin
          // [RULE16] confirm only after arm
          if (cmd == CMD_CONFIRM) begin
            push_valid = 1'b1;
            next_busy_factory = 1'b1;
            next_state = ST_FACTORY;
            next_status[STATUS_READY_BIT] = 1'b0;
          end else begin
            // [RULE22] sequence error
            next_status[STATUS_ERASE_BIT] = 1'b1;
            next_status[STATUS_PROG_BIT]  = 1'b1;
            next_state = ST_IDLE;
          end
        end
        ST_BUSY: begin
          // [RULE8] only status and suspend honoured
          if (cmd == CMD_READ_STATUS) begin
            next_rmode = RD_STATUS;
          end else if (cmd == CMD_SUSPEND) begin
            next_status[STATUS_SUSP_BIT] = 1'b1;
          end
        end
        default: begin
          // [RULE15] factory mode ignores commands
        end
      endcase
    end
    // Engine failure marks program error
    if (prog_fail) begin
      next_status[STATUS_PROG_BIT] = 1'b1;
    end
  end

  // [RULE21] reset to array read, status 0x80
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state        <= ST_IDLE;
      rmode        <= RD_ARRAY;
      status       <= STATUS_RESET;
      words_left   <= '0;
      busy_factory <= 1'b0;
    end else if (clk_en) begin
      state        <= next_state;
      rmode        <= next_rmode;
      status       <= next_status;
      words_left   <= next_words_left;
      busy_factory <= next_busy_factory;
    end
  end

  // [RULE23] mode held in register until changed
  assign read_mode  = rmode;
  assign status_reg = status;

  // Buffer control; a word arriving while full and not draining is dropped
  assign push_ready = (fill != 2'd2) || prog_ready;
  always_comb begin
    next_slot0    = slot[0];
    next_slot1    = slot[1];
    next_fill     = fill;
    next_push_fac = push_fac;
    // [RULE18] engine drains words on its own
    if (prog_valid && prog_ready) begin
      next_slot0 = slot[1];
      next_fill  = fill - 2'd1;
    end
    if (push_valid && push_ready) begin
      next_push_fac = next_busy_factory;
      if (next_fill == 2'd0) begin
        next_slot0 = {push_addr, push_data};
      end else begin
        next_slot1 = {push_addr, push_data};
      end
      next_fill = next_fill + 2'd1;
    end
  end

  // Buffer registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      slot[0]  <= '0;
      slot[1]  <= '0;
      fill     <= 2'd0;
      push_fac <= 1'b0;
    end else if (clk_en) begin
      slot[0]  <= next_slot0;
      slot[1]  <= next_slot1;
      fill     <= next_fill;
      push_fac <= next_push_fac;
    end
  end

  assign prog_valid   = (fill != 2'd0);
  assign prog_addr    = slot[0][AW+15:16];
  assign prog_data    = slot[0][15:0];
  assign prog_factory = push_fac;

  // Assertions
  a_reset_mode: assert property (@(posedge sys_clk)
    $rose(nrst) |-> rmode == RD_ARRAY && status == STATUS_RESET) // [RULE21]
    else $error("reset state wrong");
  a_array_cmd: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && write_edge && state == ST_IDLE && cmd == CMD_READ_ARRAY
    |=> rmode == RD_ARRAY) // [RULE1]
    else $error("array command ignored");
  a_status_cmd: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && write_edge && state != ST_FACTORY && cmd == CMD_READ_STATUS
    && state != ST_WORD_ADDR && state != ST_BUF_DATA && state != ST_BUF_COUNT
    |=> rmode == RD_STATUS) // [RULE2]
    else $error("status command ignored");
  a_id_cmd: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && write_edge && state == ST_IDLE && cmd == CMD_READ_ID
    |=> rmode == RD_ID) // [RULE4]
    else $error("id command ignored");
  a_query_cmd: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && write_edge && state == ST_IDLE && cmd == CMD_READ_QUERY
    |=> rmode == RD_QUERY) // [RULE5]
    else $error("query command ignored");
  a_word_push: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && write_edge && state == ST_WORD_ADDR && fill == 2'd0
    |=> prog_valid && prog_addr == $past(bus_addr) && rmode == RD_STATUS) // [RULE7]
    else $error("word program not latched");
  a_busy_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && write_edge && state == ST_BUSY && cmd == CMD_READ_ARRAY && !prog_done
    |=> $stable(rmode)) // [RULE8]
    else $error("busy accepted command");
  a_factory_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && state == ST_FACTORY && !prog_done |=> $stable(rmode)) // [RULE15]
    else $error("factory accepted command");
  a_seq_error: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && write_edge && state == ST_FACTORY_ARM && cmd != CMD_CONFIRM
    |=> status[STATUS_ERASE_BIT] && status[STATUS_PROG_BIT]) // [RULE22]
    else $error("sequence error not flagged");
  a_err_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && $past(clk_en) && $fell(status[STATUS_PROG_BIT])
    |-> $past(write_edge && cmd == CMD_CLEAR_STATUS)) // [RULE6]
    else $error("error bit cleared wrongly");
  c_word_prog: cover property (@(posedge sys_clk) state == ST_WORD_ADDR ##[1:20] state == ST_BUSY);
  c_buf_prog: cover property (@(posedge sys_clk) state == ST_BUF_CONFIRM ##1 state == ST_BUSY);
  c_factory: cover property (@(posedge sys_clk) state == ST_FACTORY);
  c_buf_full: cover property (@(posedge sys_clk) fill == 2'd2);
endmodule

// ---- verification/fcd_engine_model.sv ----
// Array engine model: takes program words and reports completion
`timescale 1ns/1ps
module fcd_engine_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Word handshake from the decoder
  input  wire logic        prog_valid,
  output logic             prog_ready,
  input  wire logic [15:0] prog_addr,
  input  wire logic [15:0] prog_data,
  // Completion back to the decoder
  output logic             prog_done,
  output logic             prog_fail,
  // Bench controls and observed words
  input  wire logic        hold,
  input  wire logic        finish,
  input  wire logic        fail_next,
  output int               taken,
  output logic [15:0]      last_addr,
  output logic [15:0]      last_data
);
  logic pending; // Set when a word is taken, cleared at the next completion
  // algorithm runs here, host only polls
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prog_ready <= 1'b0;
      prog_done  <= 1'b0;
      prog_fail  <= 1'b0;
      pending    <= 1'b0;
      taken      <= 0;
      last_addr  <= 16'h0000;
      last_data  <= 16'h0000;
    end else begin
      prog_done <= 1'b0;
      prog_fail <= 1'b0;
      // One-cycle ready: each word needs its own handshake; hold stalls
      prog_ready <= prog_valid && !hold && !prog_ready;
      if (prog_valid && prog_ready) begin
        taken     <= taken + 1;
        last_addr <= prog_addr;
        last_data <= prog_data;
        pending   <= 1'b1;
      end else if (finish && pending && !prog_valid) begin
        // Completion only once the buffer has drained
        prog_done <= 1'b1;
        prog_fail <= fail_next;
        pending   <= 1'b0;
      end
    end
  end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the flash command decoder
`timescale 1ns/1ps
module tb_top;
  import fcd_pkg::*;
  logic        sys_clk, nrst, cs_n, we_n;    // Clock, reset, strobes
  logic [15:0] addr, data;                   // Bus address and data
  logic [1:0]  read_mode;                    // Selected read mode
  logic [7:0]  status_reg;                   // Status byte
  logic        pv, pr, pfac, pd, pfl;        // Engine handshake
  logic        hold, fin, failn;             // Engine controls
  logic        clk_en;                       // Decoder freeze
  logic [15:0] pa, pdat, last_a, last_d;     // Word path
  int          taken, error_cnt, comparisons; // Counters
  fcd_command_decoder DUT (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
    .chip_sel_n(cs_n), .write_en_n(we_n), .bus_addr(addr), .bus_data(data),
    .read_mode(read_mode), .status_reg(status_reg), .prog_valid(pv), .prog_ready(pr),
    .prog_addr(pa), .prog_data(pdat), .prog_factory(pfac), .prog_done(pd), .prog_fail(pfl));
  fcd_engine_model u_eng (.sys_clk(sys_clk), .nrst(nrst), .prog_valid(pv), .prog_ready(pr),
    .prog_addr(pa), .prog_data(pdat), .prog_done(pd), .prog_fail(pfl), .hold(hold),
    .finish(fin), .fail_next(failn), .taken(taken), .last_addr(last_a), .last_data(last_d));
  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Compare and count
  task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One bus write; write strobe rises first, then bus is scrambled
  task automatic wr(logic [15:0] a, logic [15:0] d);
    @(posedge sys_clk);
    cs_n <= 1'b0;
    we_n <= 1'b0;
    addr <= a;
    data <= d;
    @(posedge sys_clk);
    we_n <= 1'b1;
    @(posedge sys_clk);
    cs_n <= 1'b1;
    addr <= ~a;
    data <= ~d;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic cmd(logic [7:0] c);
    wr(16'h0f00, {8'h00, c});
  endtask
  // Bounded wait for the ready bit
  // select toggled between status polls
  task automatic wait_ready();
    int n = 0;
    while (status_reg[STATUS_READY_BIT] !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      cs_n <= n[0];
      #1;
      n++;
    end
    @(posedge sys_clk);
    cs_n <= 1'b1;
    if (n >= 200) begin
      chk("ready wait", 0, 1);
      give_verdict();
    end
  endtask
  task automatic engine(logic h, logic f);
    @(posedge sys_clk);
    hold <= h;
    fin  <= f;
    #1;
  endtask
  task automatic t_reset();
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("mode at reset", read_mode, RD_ARRAY);
    chk("status at reset", status_reg, STATUS_RESET);
    chk("valid at reset", pv, 0);
    @(posedge sys_clk);
    nrst <= 1'b1;
  endtask
  // Every read command, then an unknown code that must not move the mode
  task automatic t_modes();
    logic [7:0] c [4] = '{CMD_READ_STATUS, CMD_READ_ID, CMD_READ_QUERY, CMD_READ_ARRAY};
    logic [1:0] m [4] = '{RD_STATUS, RD_ID, RD_QUERY, RD_ARRAY};
    for (int i = 0; i < 4; i++) begin
      wr({i[7:0], 8'h5a}, {8'h00, c[i]});
      chk("read mode", read_mode, m[i]);
      cmd(8'h12);
      chk("mode holds", read_mode, m[i]);
    end
    // Frozen decoder must miss a whole write
    @(posedge sys_clk);
    clk_en <= 1'b0;
    cmd(CMD_READ_ID);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("frozen write", read_mode, RD_ARRAY);
  endtask
  // Word program with stalled engine; optional failure
  task automatic t_word(logic fail);
    failn = fail;
    engine(1'b1, 1'b0);
    cmd(CMD_WORD_PROGRAM);
    wr(16'h1234, 16'hbeef);
    chk("valid stands", pv, 1);
    chk("auto status", read_mode, RD_STATUS);
    chk("busy", status_reg[STATUS_READY_BIT], 0);
    cmd(CMD_READ_ARRAY);
    chk("busy ignores", read_mode, RD_STATUS);
    engine(1'b0, 1'b1);
    wait_ready();
    engine(1'b0, 1'b0);
    chk("word addr", last_a, 16'h1234);
    chk("word data", last_d, 16'hbeef);
    chk("program error", status_reg[STATUS_PROG_BIT], fail);
    chk("stays status", read_mode, RD_STATUS);
  endtask
  task automatic t_clear();
    cmd(CMD_READ_ARRAY);
    chk("error kept", status_reg[STATUS_PROG_BIT], 1);
    cmd(CMD_CLEAR_STATUS);
    chk("error cleared", status_reg, STATUS_RESET);
  endtask
  // Four words; buffer filled while the engine stalls, then drained
  task automatic t_buffer();
    int base = taken;
    failn <= 1'b0;
    engine(1'b1, 1'b0);
    cmd(CMD_BUF_PROGRAM);
    wr(16'h2000, 16'h0003);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        chk("stalled", taken, base);
        engine(1'b0, 1'b0);
        repeat (8) @(posedge sys_clk);
        #1;
        chk("drained", taken, base + 2);
      end
      wr({8'h20, i[7:0]}, {8'ha0, i[7:0]});
    end
    cmd(CMD_CONFIRM);
    chk("busy after confirm", status_reg[STATUS_READY_BIT], 0);
    engine(1'b0, 1'b1);
    wait_ready();
    engine(1'b0, 1'b0);
    chk("buffer words", taken, base + 4);
    chk("last word", {last_a, last_d}, 32'h2003a003);
    chk("buffer no error", status_reg[STATUS_PROG_BIT], 0);
  endtask
  // Buffer load not closed by confirm
  task automatic t_seqerr();
    cmd(CMD_BUF_PROGRAM);
    wr(16'h3000, 16'h0000);
    wr(16'h3000, 16'h1111);
    cmd(CMD_READ_STATUS);
    chk("sequence error", status_reg[5:4], 2'b11);
    engine(1'b0, 1'b1);
    repeat (4) @(posedge sys_clk);
    engine(1'b0, 1'b0);
    cmd(CMD_CLEAR_STATUS);
    chk("error cleared", status_reg, STATUS_RESET);
    cmd(CMD_BUF_PROGRAM);
    wr(16'h3000, 16'h0200);
    chk("oversize count", {status_reg[5:4], read_mode}, {2'b11, RD_STATUS});
    cmd(CMD_CLEAR_STATUS);
  endtask
  // Lone confirm, then factory arm and confirm
  task automatic t_factory();
    int base = taken;
    logic [7:0] st;
    logic [1:0] md;
    cmd(CMD_CONFIRM);
    chk("lone confirm", {status_reg, taken[23:0]}, {STATUS_RESET, base[23:0]});
    cmd(CMD_FACTORY_SET);
    cmd(CMD_READ_ARRAY);
    chk("arm not confirmed", status_reg[5:4], 2'b11);
    cmd(CMD_CLEAR_STATUS);
    cmd(CMD_FACTORY_SET);
    wr(16'h0040, {8'h00, CMD_CONFIRM});
    repeat (4) @(posedge sys_clk);
    #1;
    chk("factory flag", pfac, 1);
    chk("factory word", {last_a, last_d}, {16'h0040, 8'h00, CMD_CONFIRM});
    st = status_reg;
    md = read_mode;
    cmd(CMD_READ_ARRAY);
    cmd(CMD_CLEAR_STATUS);
    chk("factory ignores", {status_reg, read_mode}, {st, md});
  endtask
  initial begin
    nrst  = 1'b0;
    cs_n  = 1'b1;
    we_n  = 1'b1;
    addr  = 16'h0000;
    data  = 16'h0000;
    hold  = 1'b0;
    fin   = 1'b0;
    failn = 1'b0;
    clk_en = 1'b1;
    error_cnt   = 0;
    comparisons = 0;
    t_reset();
    t_modes();
    t_word(1'b0);
    t_word(1'b1);
    t_clear();
    t_buffer();
    t_seqerr();
    t_factory();
    t_reset();
    cmd(CMD_READ_STATUS);
    chk("setup reissued", read_mode, RD_STATUS);
    give_verdict();
  end
endmodule
